// file: uzc_channel.sv
// serial channel zero: apb register file, transmitter, flags
// assumes apb master on pclk; rxd is an asynchronous pin
//
// Behaviour
// - extension off: divisor is high2 over low8
// - extension on: extra2, high2, low8 divisor
// - divisor zero stops the baud clock
// - baud equals bus clock over sixteen divisor
// - channel runs only with enable set
// - receiver takes frames only when enabled
// - multiprocessor mode with nine-bit data drops frames with ninth zero
// - stop select picks one or two stops
// - data mode picks eight or nine bits
// - parity generated and checked, odd or even
// - transmit interrupt gated by its enable
// - receive interrupt gated by its enable
// - ninth received bit held read-only
// - ninth transmit bit writable, parity when enabled
// - transmit flag sets on empty, write-zero clears
// - receive flag sets on full, write-zero clears
// - frame into full buffer lost, overrun set
// - framing error sticky, write-zero clears
// - parity error sticky, write-zero clears
// - data port reads rx, writes tx, FF
// - shared flag bit sets on channel request
`timescale 1ns/1ps
module uzc_channel
  import uzc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   serial_zero_irq_flag,
  output logic                   serial_irq_req
);
  logic [7:0] baud_divisor_low;
  logic [1:0] baud_divisor_high;
  logic [1:0] baud_divisor_extra;
  logic       divisor_extension_on;
  logic [7:0] serial_mode_control_one;
  logic       tx_irq_on;
  logic       rx_irq_on;
  logic       rx_ninth_bit;
  logic       tx_ninth_bit;
  logic       tx_done_flag;
  logic       rx_ready_flag;
  logic       rx_overrun_flag;
  logic       framing_error_flag;
  logic       parity_error_flag;
  logic [7:0] rx_buffer;
  logic [7:0] tx_buffer;
  logic       tx_full;

  logic        channel_on;
  logic        rx_on;
  logic        multi_on;
  logic        stop2;
  logic        nine;
  logic        par_on;
  logic        par_odd;
  logic        has_extra;
  logic [11:0] divisor;
  logic        tick;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_ninth;
  logic        rx_frame_bad;
  logic        rx_par_bad;
  logic        tx_par;
  logic        tx_ninth_eff;
  logic        req_q;
  logic        next_req;

  logic [ADDR_W-1:0] addr_q;
  logic              write_q;
  logic [7:0]        wbyte;
  logic              wr_acc;
  logic              mapped;
  logic [7:0]        next_rdata;

  assign channel_on = serial_mode_control_one[C1_CHAN_ON];
  assign rx_on      = serial_mode_control_one[C1_RX_ON];
  assign multi_on   = serial_mode_control_one[C1_MULTI];
  assign stop2      = serial_mode_control_one[C1_STOP2];
  assign nine       = serial_mode_control_one[C1_NINE];
  assign par_on     = serial_mode_control_one[C1_PAR_ON];
  assign par_odd    = serial_mode_control_one[C1_PAR_ODD];
  // the extra bit carries parity or the ninth data bit
  assign has_extra  = nine | par_on;
  assign divisor    = divisor_extension_on ? {baud_divisor_extra, baud_divisor_high, baud_divisor_low}
                                           : {2'b00, baud_divisor_high, baud_divisor_low};

  uzc_baud u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (channel_on),
    .divisor (divisor),
    .tick    (tick)
  );

  uzc_rx u_rx (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (channel_on & rx_on),
    .tick       (tick),
    .rxd        (rxd),
    .has_extra  (has_extra),
    .par_on     (par_on),
    .par_odd    (par_odd),
    .done       (rx_done),
    .data       (rx_data),
    .ninth      (rx_ninth),
    .frame_bad  (rx_frame_bad),
    .parity_bad (rx_par_bad)
  );

  // apb: setup cycle latches the request, one access cycle answers
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
  assign wbyte  = pwdata[7:0];

  always_comb begin
    mapped     = 1'b1;
    next_rdata = 8'h00;
    if (paddr == {IDX_EXT, 2'b00}) begin
      next_rdata = {7'h00, divisor_extension_on};
    end else if (paddr == {IDX_BDL, 2'b00}) begin
      next_rdata = baud_divisor_low;
    end else if (paddr == {IDX_CON1, 2'b00}) begin
      next_rdata = {1'b0, serial_mode_control_one[6:0]};
    end else if (paddr == {IDX_CON2, 2'b00}) begin
      next_rdata = {2'b00, baud_divisor_extra, tx_irq_on, rx_irq_on, baud_divisor_high};
    end else if (paddr == {IDX_STATE, 2'b00}) begin
      next_rdata = {1'b0, rx_ninth_bit, tx_ninth_eff, tx_done_flag, rx_ready_flag,
                    rx_overrun_flag, framing_error_flag, parity_error_flag};
    end else if (paddr == {IDX_IRQF, 2'b00}) begin
      next_rdata = {5'h00, serial_zero_irq_flag, 2'b00};
    end else if (paddr == {IDX_BUF, 2'b00}) begin
      next_rdata = rx_buffer;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      addr_q  <= '0;
      write_q <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : {24'h000000, next_rdata};
        addr_q  <= paddr;
        write_q <= pwrite;
      end
    end
  end

  // plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_extension_on    <= 1'b0;
      baud_divisor_low        <= RST_BDL;
      serial_mode_control_one <= RST_CON1;
      {baud_divisor_extra, tx_irq_on, rx_irq_on, baud_divisor_high} <= RST_CON2;
    end else if (wr_acc) begin
      if (addr_q == {IDX_EXT, 2'b00}) divisor_extension_on <= wbyte[0];
      if (addr_q == {IDX_BDL, 2'b00}) baud_divisor_low <= wbyte;
      if (addr_q == {IDX_CON1, 2'b00}) serial_mode_control_one <= {1'b0, wbyte[6:0]};
      if (addr_q == {IDX_CON2, 2'b00}) begin
        {baud_divisor_extra, tx_irq_on, rx_irq_on, baud_divisor_high} <= wbyte[5:0];
      end
    end
  end

  logic wr_state;
  logic wr_buf;
  assign wr_state = wr_acc && addr_q == {IDX_STATE, 2'b00};
  assign wr_buf   = wr_acc && addr_q == {IDX_BUF, 2'b00};

  // receive side flags; a hardware set beats a same-cycle clear
  logic rx_take;
  logic rx_lost;
  assign rx_take = rx_done && !(multi_on && nine && !rx_ninth) && !rx_ready_flag;
  assign rx_lost = rx_done && !(multi_on && nine && !rx_ninth) && rx_ready_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buffer          <= RST_BUF;
      rx_ninth_bit       <= 1'b0;
      rx_ready_flag      <= 1'b0;
      rx_overrun_flag    <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_buffer    <= rx_data;
        rx_ninth_bit <= rx_ninth;
      end
      if (rx_take) rx_ready_flag <= 1'b1;
      else if (wr_state && !wbyte[ST_RX_READY]) rx_ready_flag <= 1'b0;
      if (rx_lost) rx_overrun_flag <= 1'b1;
      else if (wr_state && !wbyte[ST_OVERRUN]) rx_overrun_flag <= 1'b0;
      if (rx_take && rx_frame_bad) framing_error_flag <= 1'b1;
      else if (wr_state && !wbyte[ST_FRAME]) framing_error_flag <= 1'b0;
      if (rx_take && rx_par_bad) parity_error_flag <= 1'b1;
      else if (wr_state && !wbyte[ST_PARITY]) parity_error_flag <= 1'b0;
    end
  end

  // transmitter
  uzc_state_t tx_state;
  logic [3:0] tx_ovs;
  logic [2:0] tx_bitn;
  logic [7:0] tx_shift;
  logic       tx_extra;
  logic       tx_stop_second;
  logic       tx_load;

  assign tx_par       = (^tx_buffer) ^ par_odd;
  assign tx_ninth_eff = par_on ? tx_par : tx_ninth_bit;
  // loads wait for a tick so the start bit spans sixteen full ticks; no tick, no frame
  assign tx_load      = channel_on && tx_state == S_IDLE && tx_full && tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer    <= RST_BUF;
      tx_full      <= 1'b0;
      tx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
    end else begin
      if (wr_buf) begin
        tx_buffer <= wbyte;
        tx_full   <= 1'b1;
      end else if (tx_load || !channel_on) begin
        // shutting off drops a byte still waiting to go
        tx_full <= 1'b0;
      end
      // read-only while parity owns the bit
      if (wr_state && !par_on) tx_ninth_bit <= wbyte[ST_TX9];
      if (tx_load) tx_done_flag <= 1'b1;
      else if (wr_state && !wbyte[ST_TX_DONE]) tx_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state       <= S_IDLE;
      tx_ovs         <= 4'h0;
      tx_bitn        <= 3'h0;
      tx_shift       <= 8'h00;
      tx_extra       <= 1'b0;
      tx_stop_second <= 1'b0;
      txd            <= 1'b1;
    end else if (!channel_on) begin
      // shutting off abandons any frame in flight
      tx_state <= S_IDLE;
      txd      <= 1'b1;
    end else begin
      case (tx_state)
        S_IDLE: begin
          txd            <= 1'b1;
          tx_ovs         <= 4'h0;
          tx_bitn        <= 3'h0;
          tx_stop_second <= 1'b0;
          if (tx_load) begin
            tx_shift <= tx_buffer;
            tx_extra <= tx_ninth_eff;
            tx_state <= S_START;
            txd      <= 1'b0;
          end
        end
        S_START: if (tick) begin
          tx_ovs <= tx_ovs + 4'h1;
          if (tx_ovs == OVS_LAST) begin
            txd      <= tx_shift[0];
            tx_state <= S_DATA;
          end
        end
        S_DATA: if (tick) begin
          tx_ovs <= tx_ovs + 4'h1;
          if (tx_ovs == OVS_LAST) begin
            tx_bitn <= tx_bitn + 3'h1;
            if (tx_bitn == DATA_LAST) begin
              tx_state <= has_extra ? S_EXTRA : S_STOP;
              txd      <= has_extra ? tx_extra : 1'b1;
            end else begin
              tx_shift <= {1'b0, tx_shift[7:1]};
              txd      <= tx_shift[1];
            end
          end
        end
        S_EXTRA: if (tick) begin
          tx_ovs <= tx_ovs + 4'h1;
          if (tx_ovs == OVS_LAST) begin
            txd      <= 1'b1;
            tx_state <= S_STOP;
          end
        end
        S_STOP: if (tick) begin
          tx_ovs <= tx_ovs + 4'h1;
          if (tx_ovs == OVS_LAST) begin
            if (stop2 && !tx_stop_second) tx_stop_second <= 1'b1;
            else tx_state <= S_IDLE;
          end
        end
        default: tx_state <= S_IDLE;
      endcase
    end
  end

  // request and shared flag; the flag sets on a rising request
  assign next_req = (tx_done_flag & tx_irq_on) | (rx_ready_flag & rx_irq_on);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q                <= 1'b0;
      serial_irq_req       <= 1'b0;
      serial_zero_irq_flag <= 1'b0;
    end else begin
      req_q          <= next_req;
      serial_irq_req <= next_req;
      if (next_req && !req_q) serial_zero_irq_flag <= 1'b1;
      else if (wr_acc && addr_q == {IDX_IRQF, 2'b00} && !wbyte[IRQF_CHAN]) begin
        serial_zero_irq_flag <= 1'b0;
      end
    end
  end
endmodule : uzc_channel

// file: uzc_pkg.sv
// constants for the serial channel: register indices, field positions, reset values
// assumes an apb slave with 32-bit data, one register per aligned word
package uzc_pkg;
  localparam int          ADDR_W        = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_EXT       = 10'h0d0;
  localparam logic [9:0]  IDX_BDL       = 10'h0dc;
  localparam logic [9:0]  IDX_CON1      = 10'h0dd;
  localparam logic [9:0]  IDX_CON2      = 10'h0de;
  localparam logic [9:0]  IDX_STATE     = 10'h0df;
  localparam logic [9:0]  IDX_IRQF      = 10'h0e1;
  localparam logic [9:0]  IDX_BUF       = 10'h0e2;
  // control one fields
  localparam int          C1_CHAN_ON    = 6;
  localparam int          C1_RX_ON      = 5;
  localparam int          C1_MULTI      = 4;
  localparam int          C1_STOP2      = 3;
  localparam int          C1_NINE       = 2;
  localparam int          C1_PAR_ON     = 1;
  localparam int          C1_PAR_ODD    = 0;
  // control two fields
  localparam int          C2_EXTRA_LO   = 4;
  localparam int          C2_TX_IRQ     = 3;
  localparam int          C2_RX_IRQ     = 2;
  // status fields
  localparam int          ST_RX9        = 6;
  localparam int          ST_TX9        = 5;
  localparam int          ST_TX_DONE    = 4;
  localparam int          ST_RX_READY   = 3;
  localparam int          ST_OVERRUN    = 2;
  localparam int          ST_FRAME      = 1;
  localparam int          ST_PARITY     = 0;
  localparam int          IRQF_CHAN     = 2;
  // reset values
  localparam logic [7:0]  RST_BDL       = 8'h00;
  localparam logic [7:0]  RST_CON1      = 8'h00;
  localparam logic [5:0]  RST_CON2      = 6'h0c;
  localparam logic [7:0]  RST_BUF       = 8'hff;
  // bit timing
  localparam int          PCLK_PERIOD_NS = 8;
  localparam logic [3:0]  OVS_LAST      = 4'hf;
  localparam logic [3:0]  OVS_MID       = 4'h7;
  localparam logic [2:0]  DATA_LAST     = 3'h7;
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_EXTRA, S_STOP} uzc_state_t;
endpackage : uzc_pkg

// file: uzc_baud.sv
// sixteen-times oversampling tick generator
// assumes divisor is steady between frames
`timescale 1ns/1ps
module uzc_baud
  import uzc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic [11:0] divisor,
  output logic             tick
);
  logic [11:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 12'h000;
      tick  <= 1'b0;
    end else if (!run || divisor == 12'h000) begin
      count <= 12'h000;
      tick  <= 1'b0;
    end else if (count >= divisor - 12'h001) begin
      count <= 12'h000;
      tick  <= 1'b1;
    end else begin
      count <= count + 12'h001;
      tick  <= 1'b0;
    end
  end
endmodule : uzc_baud

// file: uzc_rx.sv
// receiver: synchronises the line, finds start, samples mid-bit
// assumes tick pulses at sixteen times the baud rate
`timescale 1ns/1ps
module uzc_rx
  import uzc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       rxd,
  input  wire logic       has_extra,
  input  wire logic       par_on,
  input  wire logic       par_odd,
  output logic            done,
  output logic [7:0]      data,
  output logic            ninth,
  output logic            frame_bad,
  output logic            parity_bad
);
  uzc_state_t state;
  logic       sync1;
  logic       line;
  logic       line_q;
  logic [3:0] ovs;
  logic [2:0] bitn;

  // two stages before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1  <= 1'b1;
      line   <= 1'b1;
      line_q <= 1'b1;
    end else begin
      sync1  <= rxd;
      line   <= sync1;
      line_q <= line;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= S_IDLE;
      ovs        <= 4'h0;
      bitn       <= 3'h0;
      data       <= 8'h00;
      ninth      <= 1'b0;
      done       <= 1'b0;
      frame_bad  <= 1'b0;
      parity_bad <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!run) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            ovs  <= 4'h0;
            bitn <= 3'h0;
            // falling edge only: a line still low after a bad stop bit is no new start
            if (line_q && !line) state <= S_START;
          end
          S_START: if (tick) begin
            ovs <= ovs + 4'h1;
            if (ovs == OVS_MID) begin
              ovs   <= 4'h0;
              // a glitch shorter than half a bit is not a start
              state <= line ? S_IDLE : S_DATA;
            end
          end
          S_DATA: if (tick) begin
            ovs <= ovs + 4'h1;
            if (ovs == OVS_LAST) begin
              data <= {line, data[7:1]};
              bitn <= bitn + 3'h1;
              if (bitn == DATA_LAST) state <= has_extra ? S_EXTRA : S_STOP;
            end
          end
          S_EXTRA: if (tick) begin
            ovs <= ovs + 4'h1;
            if (ovs == OVS_LAST) begin
              ninth <= line;
              state <= S_STOP;
            end
          end
          S_STOP: if (tick) begin
            ovs <= ovs + 4'h1;
            if (ovs == OVS_LAST) begin
              frame_bad  <= ~line;
              parity_bad <= par_on && ((^data ^ ninth) != par_odd);
              done       <= 1'b1;
              state      <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule : uzc_rx

// file: uzc_channel_asserts.sv
// assertion checker on the serial channel top ports
// assumes one pclk domain; bound onto uzc_channel below
`timescale 1ns/1ps
module uzc_channel_asserts
  import uzc_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rxd,
  input wire logic              txd,
  input wire logic              serial_zero_irq_flag,
  input wire logic              serial_irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_irqf_clear;
    wr_done && paddr == {IDX_IRQF, 2'b00} && !pwdata[IRQF_CHAN];
  endsequence
  sequence s_flags_clear;
    wr_done && paddr == {IDX_STATE, 2'b00} && pwdata[4:3] == 2'b00;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_low_bit_min: assert property ($fell(txd) |-> !txd [*8])
    else $error("low bit on txd too short");
  chk_flag_follows_req: assert property ($rose(serial_irq_req) |-> ##[0:1] serial_zero_irq_flag)
    else $error("shared flag not set by request");
  chk_flag_write_clear: assert property (s_irqf_clear |=> !serial_zero_irq_flag || $rose(serial_irq_req))
    else $error("shared flag not cleared");
  chk_req_drops: assert property (s_flags_clear |-> ##[1:2] !serial_irq_req)
    else $error("request stays after flags cleared");
endmodule : uzc_channel_asserts

bind uzc_channel uzc_channel_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
  .serial_zero_irq_flag(serial_zero_irq_flag), .serial_irq_req(serial_irq_req)
);

// file: uzc_peer.sv
// remote serial peer: sends frames on rxd, decodes frames seen on txd
// assumes a bit time of BIT_CYC pclk cycles; the line idles high
`timescale 1ns/1ps
module uzc_peer #(
  parameter int BIT_CYC = 32
) (
  input  wire logic       pclk,
  input  wire logic       txd,
  output logic            rxd,
  output logic [8:0]      got,
  output int              got_cnt
);
  initial rxd = 1'b1;
  // start low, bits lsb first, one stop of the given level, then idle high
  task automatic send(input logic [8:0] bits, input int nb, input logic stop_lvl);
    for (int i = -1; i <= nb; i++) begin
      @(posedge pclk);
      rxd <= (i < 0) ? 1'b0 : (i == nb) ? stop_lvl : bits[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask : send
  // samples mid-bit; keeps eight data bits and the bit after them
  initial begin
    got = '0;
    got_cnt = 0;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge pclk);
        got[i] = txd;
      end
      got_cnt++;
    end
  end
endmodule : uzc_peer

// file: tb_uzc_channel.sv
// testbench for the serial channel: apb register tasks and frames with the peer
// assumes divisor 2, so the peer runs 32 pclk per bit
`timescale 1ns/1ps
module tb_uzc_channel;
  import uzc_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, rxd, txd, irqf, irq_req, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [8:0]        got;
  int                got_cnt, err_count, compares, n;

  uzc_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .serial_zero_irq_flag(irqf), .serial_irq_req(irq_req));
  uzc_peer #(.BIT_CYC(32)) peer (.pclk(pclk), .txd(txd), .rxd(rxd), .got(got), .got_cnt(got_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic fail_out;
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    wrap_up();
  endtask : fail_out
  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) fail_out();
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rd_chk
  task automatic poll(input logic [9:0] idx, input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, idx, 8'h00);
      k++;
    end while (rd[b] !== v && k < 600);
    check(32'(rd[b]), 32'(v));
  endtask : poll
  task automatic wait_txd(input logic v, input int lim);
    n = 0;
    while (txd !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (txd !== v) fail_out();
  endtask : wait_txd
  // every byte sent here has bit 0 set, so the first low stretch is the start bit
  task automatic tx_frame(input logic [7:0] d, input logic [8:0] exp);
    int k;
    k = got_cnt;
    wr(IDX_BUF, d);
    wait_txd(1'b0, 100);
    wait_txd(1'b1, 200);
    check(32'(n), 32'd32);
    n = 0;
    while (got_cnt == k && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (got_cnt == k) fail_out();
    check(32'(got), 32'(exp));
    repeat (64) @(posedge pclk);
  endtask : tx_frame

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    fail_out();
  end
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    err_count = 0;
    compares  = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(IDX_CON1, RST_CON1);
    rd_chk(IDX_CON2, {2'b00, RST_CON2});
    rd_chk(IDX_STATE, 8'h00);
    rd_chk(IDX_IRQF, 8'h00);
    rd_chk(IDX_BUF, RST_BUF);
    wr(10'h000, 8'h5a);
    check(32'(err), 32'd1);
    apb(1'b0, 10'h000, 8'h00);
    check({rd[31:1], err}, 32'h1);
    // divisor zero: a loaded byte must not reach the line
    wr(IDX_CON1, 8'h40);
    wr(IDX_BUF, 8'h00);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      if (txd !== 1'b1) n++;
    end
    check(32'(n), 32'd0);
    wr(IDX_CON1, 8'h00);
    // extra bits present but extension off, so divisor stays 2
    wr(IDX_BDL, 8'h02);
    wr(IDX_CON2, 8'h10);
    wr(IDX_STATE, 8'h00);
    wr(IDX_CON1, 8'h60);
    tx_frame(8'ha5, 9'h1a5);
    poll(IDX_STATE, ST_TX_DONE, 1'b1);
    wr(IDX_STATE, 8'h10);
    poll(IDX_STATE, ST_TX_DONE, 1'b1);
    wr(IDX_STATE, 8'h00);
    rd_chk(IDX_STATE, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(IDX_CON1, 8'h62 | 8'(p));
      tx_frame(8'h03, {1'(p), 8'h03});
    end
    wr(IDX_CON1, 8'h64);
    wr(IDX_STATE, 8'h20);
    tx_frame(8'h81, 9'h181);
    check(32'(irq_req), 32'd0);
    wr(IDX_CON2, 8'h18);
    repeat (2) @(posedge pclk);
    check(32'(irq_req), 32'd1);
    wr(IDX_CON2, 8'h10);
    // two stops: ten bit times after the start bit, one tick of wait, less the three-cycle write
    wr(IDX_CON1, 8'h68);
    wr(IDX_BUF, 8'hff);
    wait_txd(1'b0, 100);
    wait_txd(1'b1, 200);
    wr(IDX_BUF, 8'hff);
    wait_txd(1'b0, 500);
    check(32'(n), 32'd319);
    repeat (400) @(posedge pclk);
    wr(IDX_STATE, 8'h00);
    wr(IDX_CON1, 8'h60);
    peer.send(9'h03c, 8, 1'b1);
    poll(IDX_STATE, ST_RX_READY, 1'b1);
    rd_chk(IDX_BUF, 8'h3c);
    peer.send(9'h0c3, 8, 1'b1);
    poll(IDX_STATE, ST_OVERRUN, 1'b1);
    rd_chk(IDX_BUF, 8'h3c);
    wr(IDX_STATE, 8'h00);
    peer.send(9'h055, 8, 1'b0);
    poll(IDX_STATE, ST_FRAME, 1'b1);
    wr(IDX_STATE, 8'h02);
    poll(IDX_STATE, ST_FRAME, 1'b1);
    wr(IDX_STATE, 8'h00);
    poll(IDX_STATE, ST_FRAME, 1'b0);
    // even parity with a wrong parity bit
    wr(IDX_CON1, 8'h62);
    peer.send(9'h001, 9, 1'b1);
    poll(IDX_STATE, ST_PARITY, 1'b1);
    wr(IDX_CON1, 8'h64);
    wr(IDX_STATE, 8'h00);
    wr(IDX_IRQF, 8'h00);
    wr(IDX_CON2, 8'h04);
    peer.send(9'h15a, 9, 1'b1);
    poll(IDX_STATE, ST_RX9, 1'b1);
    rd_chk(IDX_BUF, 8'h5a);
    check(32'(irq_req), 32'd1);
    rd_chk(IDX_IRQF, 8'h04);
    wr(IDX_IRQF, 8'h00);
    rd_chk(IDX_IRQF, 8'h00);
    wr(IDX_STATE, 8'h00);
    rd_chk(IDX_STATE, 8'h40);
    check(32'(irq_req), 32'd0);
    wr(IDX_CON1, 8'h40);
    peer.send(9'h077, 8, 1'b1);
    rd_chk(IDX_STATE, 8'h40);
    // multiprocessor: ninth bit zero is dropped, ninth bit one is taken
    wr(IDX_CON1, 8'h74);
    peer.send(9'h011, 9, 1'b1);
    peer.send(9'h122, 9, 1'b1);
    poll(IDX_STATE, ST_RX_READY, 1'b1);
    rd_chk(IDX_BUF, 8'h22);
    // extension on makes the divisor 1026: 100 cycles on, a divisor of 2 would already show data ones
    wr(IDX_EXT, 8'h01);
    wr(IDX_CON2, 8'h14);
    wr(IDX_CON1, 8'h40);
    wr(IDX_BUF, 8'hff);
    wait_txd(1'b0, 1100);
    repeat (100) @(posedge pclk);
    check(32'(txd), 32'd0);
    wr(IDX_CON1, 8'h00);
    wait_txd(1'b1, 8);
    check(32'(txd), 32'd1);
    wrap_up();
  end
endmodule : tb_uzc_channel
